// [hdl/corr_pkg.sv]
/*
  shared constants and types for the serial bit correlator.
  assumes nothing beyond a SystemVerilog compiler.
*/
package corr_pkg;
  localparam int TAP_W = 64;
  localparam int SCORE_W = 7;
  localparam int HALF_W = TAP_W / 2;
  localparam int PART_W = SCORE_W - 1;
  localparam int SYNC_DEPTH = 2;
  localparam logic [TAP_W-1:0] TAP_CLEAR = 64'h0;
  localparam logic [SCORE_W-1:0] SCORE_CLEAR = 7'h0;
  localparam logic [PART_W-1:0] PART_CLEAR = 6'h0;

  // every pin that enters from outside the clock domain
  typedef struct packed {
    logic sample_d;
    logic template_d;
    logic mask_d;
    logic sample_clk;
    logic template_clk;
    logic mask_clk;
    logic threshold_clk;
    logic summer_clk;
    logic template_copy_ctl;
    logic output_complement_ctl;
    logic output_hiz_ctl;
    logic [SCORE_W-1:0] score_pins;
  } pin_s;

  localparam pin_s PINS_CLEAR = '0;
endpackage

// [hdl/sum_if.sv]
/*
  link between the correlator front end and its pipelined summer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sum_if
  import corr_pkg::*;
();
  logic [TAP_W-1:0] match_vec;
  logic advance;
  logic [SCORE_W-1:0] threshold;
  logic [SCORE_W-1:0] score;
  logic hit;

  modport feed (output match_vec, output advance, output threshold, input score, input hit);
  modport sum (input match_vec, input advance, input threshold, output score, output hit);
endinterface

// [hdl/match_summer.sv]
/*
  three stage pipelined population count of the masked match vector,
  with the threshold comparison in the last stage.
  assumes advance is a one-cycle pulse, one per summer clock edge.
*/
`timescale 1ns/1ps
module match_summer
  import corr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // link to the front end
  sum_if.sum bus
);
  logic [TAP_W-1:0] vec_ff;
  logic [TAP_W-1:0] nxt_vec;
  logic [PART_W-1:0] lo_ff;
  logic [PART_W-1:0] nxt_lo;
  logic [PART_W-1:0] hi_ff;
  logic [PART_W-1:0] nxt_hi;
  logic [SCORE_W-1:0] score_ff;
  logic [SCORE_W-1:0] nxt_score;
  logic hit_ff;
  logic nxt_hit;

  function automatic logic [PART_W-1:0] count_ones(input logic [HALF_W-1:0] v);
    logic [PART_W-1:0] c;
    c = PART_CLEAR;
    for (int i = 0; i < HALF_W; i++)
    begin
      c = c + PART_W'(v[i]);
    end
    return c;
  endfunction

  always_comb
  begin
    nxt_vec = vec_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_score = score_ff;
    nxt_hit = hit_ff;
    // each edge moves every stage one step: score lands on the third edge
    if (bus.advance)
    begin
      nxt_vec = bus.match_vec;
      nxt_lo = count_ones(vec_ff[HALF_W-1:0]);
      nxt_hi = count_ones(vec_ff[TAP_W-1:HALF_W]);
      nxt_score = SCORE_W'(lo_ff) + SCORE_W'(hi_ff);
      nxt_hit = (nxt_score >= bus.threshold);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      vec_ff <= TAP_CLEAR;
      lo_ff <= PART_CLEAR;
      hi_ff <= PART_CLEAR;
      score_ff <= SCORE_CLEAR;
      hit_ff <= 1'b0;
    end
    else
    begin
      vec_ff <= nxt_vec;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      score_ff <= nxt_score;
      hit_ff <= nxt_hit;
    end
  end

  assign bus.score = score_ff;
  assign bus.hit = hit_ff;
endmodule

// [hdl/bit_correlator.sv]
/*
  64 position serial bit correlator: sample, template and mask shift
  registers, reference latch, pipelined summer, threshold and output logic.
  assumes all pin clocks are slow enough to be sampled by clk_in
  (each level held for at least three clk_in cycles).
*/
// Summary of operation
// - output-complement high inverts all seven score bits on the pins.
// - output-hiz high releases the score pins; low drives the score.
// - threshold loads from score pins only while released; host drives them then.
// - template-copy control copies the whole template into the reference latch.
// - copy control held high makes the latch follow the template; low holds.
// - sample, template, mask registers each shift only on their own clock.
// - threshold register loads only on its own threshold clock.
// - summer advances on its own clock, capturing the current comparison each edge.
// - mask loads serially; a zero mask bit removes that position's match.
// - sample register: 64 positions, one bit per rising edge of its clock.
// - score for an alignment appears two summer clock edges after capture.
// - threshold flag set at each summer edge: high when the new score is at least the threshold, 0 to 127.
// - each threshold clock rising edge while output-hiz is high captures the score pins into threshold.
// - score is unsigned count of unmasked agreeing positions, top pin is msb.
`timescale 1ns/1ps
module bit_correlator
  import corr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // serial data
  input wire logic sample_serial_in,
  input wire logic template_serial_in,
  input wire logic mask_serial_in,
  // pin clocks
  input wire logic sample_clk_in,
  input wire logic template_clk_in,
  input wire logic mask_clk_in,
  input wire logic threshold_clk_in,
  input wire logic summer_clk_in,
  // controls
  input wire logic template_copy_ctl_in,
  input wire logic output_complement_ctl_in,
  input wire logic output_hiz_ctl_in,
  // score pins, two-way
  input wire logic [SCORE_W-1:0] score_pins_in,
  output logic [SCORE_W-1:0] score_pins_out,
  output logic score_pins_oe_out,
  // flag
  output logic threshold_hit_flag_out
);
  logic [SYNC_DEPTH-1:0] rst_sync_ff;
  logic resetn;
  // pin image: raw, first stage, second stage, older copy for edges
  pin_s raw_pins;
  pin_s meta_ff;
  pin_s pins_ff;
  pin_s prev_ff;
  logic sample_rise;
  logic template_rise;
  logic mask_rise;
  logic threshold_rise;
  logic summer_rise;
  logic [TAP_W-1:0] sample_ff;
  logic [TAP_W-1:0] nxt_sample;
  logic [TAP_W-1:0] template_ff;
  logic [TAP_W-1:0] nxt_template;
  logic [TAP_W-1:0] mask_ff;
  logic [TAP_W-1:0] nxt_mask;
  logic [TAP_W-1:0] ref_ff;
  logic [TAP_W-1:0] nxt_ref;
  logic [SCORE_W-1:0] threshold_ff;
  logic [SCORE_W-1:0] nxt_threshold;
  logic [SCORE_W-1:0] out_ff;
  logic [SCORE_W-1:0] nxt_out;
  logic [TAP_W-1:0] match;

  sum_if link ();

  // reset release through two flip-flops
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_sync_ff <= '0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[SYNC_DEPTH-2:0], 1'b1};
    end
  end

  assign resetn = rst_sync_ff[SYNC_DEPTH-1];

  assign raw_pins = '{
    sample_d: sample_serial_in,
    template_d: template_serial_in,
    mask_d: mask_serial_in,
    sample_clk: sample_clk_in,
    template_clk: template_clk_in,
    mask_clk: mask_clk_in,
    threshold_clk: threshold_clk_in,
    summer_clk: summer_clk_in,
    template_copy_ctl: template_copy_ctl_in,
    output_complement_ctl: output_complement_ctl_in,
    output_hiz_ctl: output_hiz_ctl_in,
    score_pins: score_pins_in
  };

  // two-stage synchroniser plus a delayed copy for edge detection
  // only pins_ff reads meta_ff: the first stage may be metastable
  always_ff @(posedge clk_in or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= PINS_CLEAR;
      pins_ff <= PINS_CLEAR;
      prev_ff <= PINS_CLEAR;
    end
    else
    begin
      meta_ff <= raw_pins;
      pins_ff <= meta_ff;
      prev_ff <= pins_ff;
    end
  end

  // prev_ff clears low like the idle pin clocks, so no false edge after reset
  assign sample_rise = pins_ff.sample_clk & ~prev_ff.sample_clk;
  assign template_rise = pins_ff.template_clk & ~prev_ff.template_clk;
  assign mask_rise = pins_ff.mask_clk & ~prev_ff.mask_clk;
  assign threshold_rise = pins_ff.threshold_clk & ~prev_ff.threshold_clk;
  assign summer_rise = pins_ff.summer_clk & ~prev_ff.summer_clk;

  // data was sampled alongside its clock, so prev_ff holds the bit present at the edge
  always_comb
  begin
    nxt_sample = sample_ff;
    nxt_template = template_ff;
    nxt_mask = mask_ff;
    nxt_ref = ref_ff;
    nxt_threshold = threshold_ff;
    if (sample_rise)
    begin
      nxt_sample = {sample_ff[TAP_W-2:0], prev_ff.sample_d};
    end
    if (template_rise)
    begin
      nxt_template = {template_ff[TAP_W-2:0], prev_ff.template_d};
    end
    if (mask_rise)
    begin
      nxt_mask = {mask_ff[TAP_W-2:0], prev_ff.mask_d};
    end
    // level follower: a held control tracks every template shift
    if (pins_ff.template_copy_ctl)
    begin
      nxt_ref = template_ff;
    end
    // a threshold edge while the pins are driven is dropped without trace
    if (threshold_rise && pins_ff.output_hiz_ctl)
    begin
      nxt_threshold = prev_ff.score_pins;
    end
    // complement at the output flop: shows one cycle after the synced control
    if (pins_ff.output_complement_ctl)
    begin
      nxt_out = ~link.score;
    end
    else
    begin
      nxt_out = link.score;
    end
  end

  always_ff @(posedge clk_in or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_ff <= TAP_CLEAR;
      template_ff <= TAP_CLEAR;
      mask_ff <= TAP_CLEAR;
      ref_ff <= TAP_CLEAR;
      threshold_ff <= SCORE_CLEAR;
      out_ff <= SCORE_CLEAR;
    end
    else
    begin
      sample_ff <= nxt_sample;
      template_ff <= nxt_template;
      mask_ff <= nxt_mask;
      ref_ff <= nxt_ref;
      threshold_ff <= nxt_threshold;
      out_ff <= nxt_out;
    end
  end

  // position 0 holds the newest bit of every register
  // agreement per position, gated by the mask
  genvar g;
  generate
    for (g = 0; g < TAP_W; g++)
    begin : g_match
      assign match[g] = ~(sample_ff[g] ^ ref_ff[g]) & mask_ff[g];
    end
  endgenerate

  // the summer sees pin events through the same synchroniser depth
  assign link.match_vec = match;
  assign link.advance = summer_rise;
  assign link.threshold = threshold_ff;

  match_summer summer (
    .clk_in(clk_in),
    .resetn_in(resetn),
    .bus(link.sum)
  );

  // enable comes straight from the second sync stage, so it cannot glitch
  assign score_pins_out = out_ff;
  assign score_pins_oe_out = ~pins_ff.output_hiz_ctl;
  assign threshold_hit_flag_out = link.hit;
endmodule

// [bench/corr_monitor.sv]
/* pin-level checker for bit_correlator.
   assumes pin clocks and controls hold each level 3+ clk_in cycles. */
`timescale 1ns/1ps
module corr_monitor
  import corr_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic summer_clk_in,
  input wire logic threshold_clk_in,
  input wire logic output_complement_ctl_in,
  input wire logic output_hiz_ctl_in,
  input wire logic [SCORE_W-1:0] score_pins_in,
  input wire logic [SCORE_W-1:0] score_pins_out,
  input wire logic score_pins_oe_out,
  input wire logic threshold_hit_flag_out
);
  logic [3:0] quiet_ff, nxt_quiet;
  logic [1:0] sums_ff, nxt_sums;
  logic [SCORE_W-1:0] thr_ff, nxt_thr, held_ff, nxt_held;
  logic sclk_ff, tclk_ff, comp_ff;
  // quiet counts cycles since anything could move the outputs
  always_comb
  begin
    nxt_quiet = (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
    nxt_sums = sums_ff;
    nxt_thr = thr_ff;
    nxt_held = (quiet_ff > 4'h8) ? score_pins_out : held_ff;
    if (summer_clk_in && !sclk_ff)
    begin
      nxt_quiet = 4'h0;
      nxt_sums = (sums_ff == 2'h3) ? sums_ff : sums_ff + 2'h1;
    end
    if (threshold_clk_in && !tclk_ff && output_hiz_ctl_in)
    begin
      nxt_quiet = 4'h0;
      nxt_sums = 2'h0;
      nxt_thr = score_pins_in;
    end
    if (output_complement_ctl_in != comp_ff)
      nxt_quiet = 4'h0;
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      quiet_ff <= 4'h0;
      sums_ff <= 2'h0;
      thr_ff <= 7'h00;
      held_ff <= 7'h00;
      sclk_ff <= 1'b0;
      tclk_ff <= 1'b0;
      comp_ff <= 1'b0;
    end
    else
    begin
      quiet_ff <= nxt_quiet;
      sums_ff <= nxt_sums;
      thr_ff <= nxt_thr;
      held_ff <= nxt_held;
      sclk_ff <= summer_clk_in;
      tclk_ff <= threshold_clk_in;
      comp_ff <= output_complement_ctl_in;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence settled;
    quiet_ff > 4'h8;
  endsequence
  sequence rel_ready;
    quiet_ff > 4'h8 && sums_ff == 2'h3 && !output_complement_ctl_in;
  endsequence
  hiz_release_a: assert property ($rose(output_hiz_ctl_in) |-> ##[1:6] !score_pins_oe_out)
    else $error("pins still driven after release");
  hiz_drive_a: assert property ($fell(output_hiz_ctl_in) |-> ##[1:6] score_pins_oe_out)
    else $error("pins not driven again");
  load_window_a: assert property (output_hiz_ctl_in [*8] |-> !score_pins_oe_out)
    else $error("pins driven during load window");
  score_hold_a: assert property (settled |-> $stable(score_pins_out))
    else $error("score moved without summer edge");
  flag_hold_a: assert property (settled |-> $stable(threshold_hit_flag_out))
    else $error("flag moved without summer edge");
  complement_flip_a: assert property ((output_complement_ctl_in != comp_ff && quiet_ff > 4'h8)
    |-> ##[2:8] score_pins_out == ~held_ff)
    else $error("pins not complemented");
  flag_rel_a: assert property (rel_ready |->
    threshold_hit_flag_out == (score_pins_out >= thr_ff))
    else $error("flag disagrees with threshold");
  score_range_a: assert property (rel_ready |-> score_pins_out <= 7'h40)
    else $error("score above 64");
endmodule
bind bit_correlator corr_monitor mon (.clk_in, .resetn_in, .summer_clk_in, .threshold_clk_in,
  .output_complement_ctl_in, .output_hiz_ctl_in, .score_pins_in, .score_pins_out,
  .score_pins_oe_out, .threshold_hit_flag_out);

// [bench/host_pins.sv]
/* host side of the score pins: resolves the shared wire.
   assumes the host drives only while the device has released. */
`timescale 1ns/1ps
module host_pins
  import corr_pkg::*;
(
  input wire logic clk_in,
  input wire logic dev_oe_in,
  input wire logic [SCORE_W-1:0] dev_pins_in,
  input wire logic host_en_in,
  input wire logic [SCORE_W-1:0] host_pins_in,
  output logic [SCORE_W-1:0] wire_out
);
  logic [SCORE_W-1:0] last_ff;
  always_ff @(posedge clk_in)
    last_ff <= wire_out;
  // undriven wire toggles so a stale value is never read as valid
  always_comb
    wire_out = dev_oe_in ? dev_pins_in : (host_en_in ? host_pins_in : ~last_ff);
endmodule

// [bench/serial_bit_correlator_pins_tb_top.sv]
/* pin-level bench for bit_correlator.
   assumes host_pins resolves the score wire and the checker is bound. */
`timescale 1ns/1ps
module serial_bit_correlator_pins_tb_top
  import corr_pkg::*;
;
  localparam logic [TAP_W-1:0] PAT = 64'hF0E1D2C3B4A59687;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] pclk = 5'h00;
  logic [2:0] sdat = 3'h0;
  logic cp = 1'b0, cmp = 1'b0, hz = 1'b0, hen = 1'b0, oe, flag;
  logic [SCORE_W-1:0] hd = 7'h00, wire_v, pins, thr = 7'h00, last = 7'h00;
  logic [TAP_W-1:0] mdl [4];
  int miscompares = 0;
  int check_count = 0;
  initial forever #2 clk_in = ~clk_in;
  bit_correlator dut (.clk_in, .resetn_in, .sample_serial_in(sdat[0]),
    .template_serial_in(sdat[1]), .mask_serial_in(sdat[2]), .sample_clk_in(pclk[0]),
    .template_clk_in(pclk[1]), .mask_clk_in(pclk[2]), .threshold_clk_in(pclk[3]),
    .summer_clk_in(pclk[4]), .template_copy_ctl_in(cp), .output_complement_ctl_in(cmp),
    .output_hiz_ctl_in(hz), .score_pins_in(wire_v), .score_pins_out(pins),
    .score_pins_oe_out(oe), .threshold_hit_flag_out(flag));
  host_pins host (.clk_in, .dev_oe_in(oe), .dev_pins_in(pins), .host_en_in(hen),
    .host_pins_in(hd), .wire_out(wire_v));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [SCORE_W-1:0] seen, input logic [SCORE_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input int w);
    tick(4);
    pclk[w] = 1'b1;
    tick(4);
    pclk[w] = 1'b0;
  endtask
  task automatic load(input int w, input logic [TAP_W-1:0] p);
    for (int i = TAP_W - 1; i >= 0; i--)
    begin
      sdat[w] = p[i];
      pulse(w);
    end
    mdl[w] = p;
  endtask
  task automatic copy();
    cp = 1'b1;
    tick(6);
    cp = 1'b0;
    mdl[3] = mdl[1];
  endtask
  function automatic logic [SCORE_W-1:0] cnt();
    cnt = 7'h00;
    for (int i = 0; i < TAP_W; i++)
      cnt += 7'(~(mdl[0][i] ^ mdl[3][i]) & mdl[2][i]);
  endfunction
  task automatic summ(input int n);
    logic [SCORE_W-1:0] e;
    e = cnt();
    pulse(4);
    pulse(4);
    tick(8);
    chk(pins, last ^ {7{cmp}});
    pulse(4);
    tick(8);
    chk(pins, e ^ {7{cmp}});
    chk(7'(flag), 7'(e >= thr));
    last = e;
    $display("test %0d done", n);
  endtask
  task automatic thload(input logic [SCORE_W-1:0] v, input logic open);
    hz = open;
    tick(8);
    chk(7'(oe), 7'(!open));
    hen = open;
    hd = v;
    pulse(3);
    hen = 1'b0;
    hz = 1'b0;
    if (open)
      thr = v;
    tick(8);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    tick(10);
    resetn_in = 1'b1;
    tick(4);
    load(2, '1);
    load(0, PAT);
    load(1, PAT);
    copy();
    summ(1);
    thload(7'h40, 1'b1);
    summ(2);
    load(2, 64'h5555555555555555);
    summ(3);
    thload(7'h00, 1'b0);
    load(1, ~PAT);
    summ(4);
    copy();
    cmp = 1'b1;
    summ(5);
    thload(7'h00, 1'b1);
    summ(6);
    cp = 1'b1;
    load(1, PAT);
    cp = 1'b0;
    mdl[3] = mdl[1];
    summ(7);
    report_and_stop();
  end
  initial
  begin
    #400000;
    miscompares++;
    $display("[FAIL] %0t run took too long", $time);
    report_and_stop();
  end
endmodule
